// ### tb/ang_lp_model.sv
// Link partner model that delivers next-page code words to the register block
`timescale 1ns/1ps

module ang_lp_model (
    input  wire logic          clock,
    output logic               page_rx_valid,
    output ang_pkg::ang_page_s page_rx_word
);
    // ****************************************************************
    // Page delivery
    // ****************************************************************
    logic tog_last = 1'b1;

    // Idle state at time zero
    initial
    begin
        page_rx_valid = 1'b0;
        page_rx_word  = 16'h5a5a;
    end

    // Sends one page; with hold set valid stays up for a following page
    task automatic send(input ang_pkg::ang_page_s w, input bit hold = 1'b0);
        w.toggle_bit  = ~tog_last;
        tog_last      = w.toggle_bit;
        page_rx_word  = w;
        page_rx_valid = 1'b1;
        @(posedge clock);
        #1;
        if (!hold)
        begin
            page_rx_valid = 1'b0;
            page_rx_word  = ~w;  // Stale word no longer shows once released
        end
    endtask
endmodule

// ### tb/tb_an_next_page_rx_and_gig_config.sv
// Self-checking bench for the next-page receive and gigabit configuration registers
`timescale 1ns/1ps

module tb_an_next_page_rx_and_gig_config;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic                    clock = 1'b0;
    logic                    sys_rst = 1'b1;
    logic [4:0]              mgmt_addr = 5'h00;
    logic                    mgmt_wr = 1'b0;
    logic                    mgmt_rd = 1'b0;
    logic [15:0]             mgmt_wdata = 16'h0000;
    logic [15:0]             mgmt_rdata;
    logic                    mgmt_rvalid;
    logic                    mgmt_rhit;
    logic                    page_rx_valid;
    ang_pkg::ang_page_s      page_rx_word;
    logic                    link_down = 1'b0;
    ang_pkg::ang_page_s      rx_page;
    ang_pkg::ang_test_mode_e test_mode;
    logic                    ms_manual_en;
    logic                    ms_force_master;
    logic                    ms_force_slave;
    logic                    adv_multi_port;
    logic                    adv_full_duplex;
    logic                    adv_half_duplex;
    logic                    reflectometry_start;
    int                      n_mismatch = 0;
    int                      n_compared = 0;
    int                      n_cycles = 0;
    logic                    prev_tog = 1'b1;
    logic                    fd_strap = 1'b0;
    logic                    strap_fd;

    ang_regs_top u_dut (
        .clock(clock), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .mgmt_rhit(mgmt_rhit), .page_rx_valid(page_rx_valid),
        .page_rx_word(page_rx_word), .link_down(link_down), .fd_strap(fd_strap),
        .rx_page(rx_page), .test_mode(test_mode), .ms_manual_en(ms_manual_en),
        .ms_force_master(ms_force_master), .ms_force_slave(ms_force_slave),
        .adv_multi_port(adv_multi_port), .adv_full_duplex(adv_full_duplex),
        .adv_half_duplex(adv_half_duplex), .reflectometry_start(reflectometry_start)
    );

    // Strapped variant: only the full duplex reset load is watched
    ang_regs_top #(.FD_FROM_STRAP(1'b1)) u_dut_strap (
        .clock(clock), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(1'b0),
        .mgmt_rd(1'b0), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(), .mgmt_rvalid(), .mgmt_rhit(),
        .page_rx_valid(1'b0), .page_rx_word(page_rx_word), .link_down(1'b0),
        .fd_strap(fd_strap), .rx_page(), .test_mode(), .ms_manual_en(), .ms_force_master(),
        .ms_force_slave(), .adv_multi_port(), .adv_full_duplex(strap_fd),
        .adv_half_duplex(), .reflectometry_start()
    );

    ang_lp_model u_lp (
        .clock(clock), .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word)
    );

    // 10 MHz clock
    initial
    begin
        forever #50 clock = ~clock;
    end

    // Cuts a hang short after a generous cycle ceiling
    always @(posedge clock)
    begin
        n_cycles++;
        if (n_cycles == 3000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic cyc();
        @(posedge clock);
        #1;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr  = a;
        mgmt_wdata = d;
        mgmt_wr    = 1'b1;
        cyc();
        mgmt_wr    = 1'b0;
        cyc();
    endtask

    // Read answer comes right after the edge that takes the request
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic hit);
        mgmt_addr = a;
        mgmt_rd   = 1'b1;
        cyc();
        mgmt_rd   = 1'b0;
        chk1(mgmt_rvalid, 1'b1);
        chk1(mgmt_rhit, hit);
        chk16(mgmt_rdata, exp);
        cyc();
    endtask

    // Sends a page and checks the capture, bit 11 the inverse of the prior toggle
    task automatic page(input logic [15:0] w);
        logic [15:0] e;
        u_lp.send(w);
        e = {w[15:12], ~prev_tog, w[10:0]};
        prev_tog = ~prev_tog;
        chk16(rx_page, e);
        rd(5'h08, e, 1'b1);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(5'h08, 16'h2001, 1'b1);
        rd(5'h09, 16'h0300, 1'b1);
        chk1(adv_full_duplex, 1'b1);
        chk1(adv_half_duplex, 1'b1);
        chk1(strap_fd, 1'b0);
        rd(5'h1f, 16'h0000, 1'b0);
    endtask

    task automatic t_pages();
        page(16'hd555);
        page(16'h3fff);
        page(16'h0000);
        // Read-only ack and toggle survive an all-ones write
        wr(5'h08, 16'hffff);
        chk16(rx_page, (16'h0000 & 16'h4800) | 16'hb7ff);
        // Received page beats a simultaneous write
        fork
            u_lp.send(16'h9123);
            wr(5'h08, 16'h0000);
        join
        chk16(rx_page, {16'h9123 & 16'hf7ff} | {4'h0, ~prev_tog, 11'h000});
        prev_tog = ~prev_tog;
        // Two pages on consecutive edges: bit 11 is the inverse of the first one's toggle
        u_lp.send(16'h2abc, 1'b1);
        u_lp.send(16'h4def);
        chk16(rx_page, {4'h4, prev_tog, 11'h5ef});
    endtask

    task automatic t_cfg();
        for (int i = 0; i < 8; i++)
        begin
            wr(5'h09, {i[2:0], 13'h1fff});
            chk16({13'h0000, test_mode}, {13'h0000, i[2:0]});
            rd(5'h09, {i[2:0], 13'h1f80}, 1'b1);
        end
        chk1(ms_force_master, 1'b1);
        chk1(ms_force_slave, 1'b0);
        chk1(adv_multi_port, 1'b1);
        wr(5'h09, 16'h1000);  // Slave forced, no partner role modelled to clash
        chk1(ms_manual_en, 1'b1);
        chk1(ms_force_slave, 1'b1);
        chk1(adv_full_duplex, 1'b0);
        chk1(adv_half_duplex, 1'b0);
        chk1(adv_multi_port, 1'b0);
        wr(5'h09, 16'h0800);
        chk1(ms_manual_en, 1'b0);
        chk1(ms_force_master, 1'b0);
        chk1(ms_force_slave, 1'b0);
        wr(5'h1f, 16'hffff);
        rd(5'h09, 16'h0800, 1'b1);
    endtask

    // Back-to-back link drops with the automatic run enabled, then disabled
    task automatic t_drop(input logic en);
        wr(5'h09, {8'h00, en, 7'h7f});
        link_down = 1'b1;
        cyc();
        chk1(reflectometry_start, en);
        cyc();
        link_down = 1'b0;
        chk1(reflectometry_start, en);
        cyc();
        chk1(reflectometry_start, 1'b0);
    endtask

    // Reset in mid-run with the strap high: strapped variant loads it, reset values return
    task automatic t_strap();
        sys_rst  = 1'b1;
        fd_strap = 1'b1;
        repeat (4) cyc();
        sys_rst = 1'b0;
        repeat (3) cyc();
        chk1(strap_fd, 1'b1);
        chk1(adv_full_duplex, 1'b1);
        rd(5'h08, 16'h2001, 1'b1);
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        cyc();
        t_reset();
        t_pages();
        t_cfg();
        t_drop(1'b1);
        t_drop(1'b0);
        t_strap();
        finish_test();
    end
endmodule

// ### verilog/ang_page_capture.sv
// Next-page receive register: capture of link partner pages and management writes
`timescale 1ns/1ps
`include "ang_regs.svh"

module ang_page_capture (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             page_valid,
    input  wire ang_pkg::ang_page_s page_word,
    input  wire logic             wr_en,
    input  wire logic [15:0]      wdata,
    output ang_pkg::ang_page_s    page_q
);

    // ****************************************************************
    // Next value: a received page wins over a management write
    // ****************************************************************
    logic              prev_tog_r;
    ang_pkg::ang_page_s page_r;
    ang_pkg::ang_page_s rx_page;
    ang_pkg::ang_page_s page_nxt;

    // Received fields taken whole, toggle opposite of the last exchanged word
    assign rx_page = '{more_pages_flag:    page_word.more_pages_flag,
                       ack:                page_word.ack,
                       message_page_flag:  page_word.message_page_flag,
                       comply_acknowledge: page_word.comply_acknowledge,
                       toggle_bit:         ~prev_tog_r,
                       code:               page_word.code};

    // Read-only ack and toggle fall outside the write mask
    assign page_nxt = page_valid ? rx_page :
                      wr_en ? ang_pkg::ang_page_s'(ang_pkg::ang_masked_write(
                                  page_r, wdata, `ANG_PNP_WMASK)) :
                      page_r;

    // Register and last exchanged toggle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            page_r     <= ang_pkg::ang_page_s'(`ANG_PNP_RESET);
            prev_tog_r <= `ANG_TOG_RESET;
        end
        else
        begin
            page_r <= page_nxt;
            if (page_valid)
            begin
                prev_tog_r <= page_word.toggle_bit;
            end
        end
    end

    assign page_q = page_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    page_capture_a: assert property (@(posedge clock) disable iff (sys_rst)
        page_valid |=> page_r.more_pages_flag == $past(page_word.more_pages_flag)
                    && page_r.ack == $past(page_word.ack)
                    && page_r.code == $past(page_word.code))
        else $error("received page not captured");

    page_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
        page_valid |=> page_r.message_page_flag == $past(page_word.message_page_flag)
                    && page_r.comply_acknowledge == $past(page_word.comply_acknowledge))
        else $error("message page or comply flag wrong");

    toggle_inv_a: assert property (@(posedge clock) disable iff (sys_rst)
        page_valid ##1 page_valid |=> page_r.toggle_bit == !$past(page_word.toggle_bit, 2))
        else $error("toggle not inverse of previous word");

    ro_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_en && !page_valid |=> page_r.ack == $past(page_r.ack)
                    && page_r.toggle_bit == $past(page_r.toggle_bit))
        else $error("write disturbed read-only field");

endmodule

// ### verilog/ang_pkg.sv
// Types shared by the next-page and gigabit configuration register logic
package ang_pkg;

    // ****************************************************************
    // Transmitter test modes
    // ****************************************************************
    typedef enum logic [2:0] {
        ANG_TM_NORMAL     = 3'h0,
        ANG_TM_WAVEFORM   = 3'h1,
        ANG_TM_JIT_MASTER = 3'h2,
        ANG_TM_JIT_SLAVE  = 3'h3,
        ANG_TM_DISTORTION = 3'h4,
        ANG_TM_SCR_IDLE   = 3'h5,
        ANG_TM_REP_0001   = 3'h6,
        ANG_TM_PULSE_63   = 3'h7
    } ang_test_mode_e;

    // ****************************************************************
    // Next-page code word, laid out as the register reads
    // ****************************************************************
    typedef struct packed {
        logic        more_pages_flag;
        logic        ack;
        logic        message_page_flag;
        logic        comply_acknowledge;
        logic        toggle_bit;
        logic [10:0] code;
    } ang_page_s;

    // Keeps bits outside the mask, takes written bits inside it
    function automatic logic [15:0] ang_masked_write(
        input logic [15:0] cur,
        input logic [15:0] wdata,
        input logic [15:0] mask
    );
        ang_masked_write = (cur & ~mask) | (wdata & mask);
    endfunction

endpackage

// ### verilog/ang_regs.svh
// Register offsets, bit fields, reset values and masks of the next-page and gigabit registers
`ifndef ANG_REGS_SVH
`define ANG_REGS_SVH

// ****************************************************************
// Register offsets on the management register port
// ****************************************************************
`define ANG_PNP_ADDR      5'h08
`define ANG_CFG_ADDR      5'h09

// ****************************************************************
// Next-page receive register
// ****************************************************************
`define ANG_PNP_RESET     16'h2001
`define ANG_PNP_WMASK     16'hb7ff
`define ANG_TOG_RESET     1'b1

// ****************************************************************
// Gigabit configuration register
// ****************************************************************
`define ANG_CFG_RESET     16'h0300
`define ANG_CFG_WMASK     16'hff80
`define ANG_TM_HI         15
`define ANG_TM_LO         13
`define ANG_MS_MANUAL     12
`define ANG_MS_VALUE      11
`define ANG_PORT_TYPE     10
`define ANG_ADV_FD        9
`define ANG_ADV_HD        8
`define ANG_AUTO_REFL     7
`define ANG_RSVD_HI       6
`define ANG_RSVD_ZERO     7'h00

// ****************************************************************
// Strap capture and read answers
// ****************************************************************
`define ANG_STRAP_LOAD    2'h2
`define ANG_CNT_ZERO      2'h0
`define ANG_CNT_ONE       2'h1
`define ANG_CNT_DONE      2'h3
`define ANG_RD_NONE       16'h0000

`endif

// ### verilog/ang_regs_top.sv
// Next-page receive and gigabit configuration registers with their control outputs
`timescale 1ns/1ps
`include "ang_regs.svh"

module ang_regs_top #(
    parameter bit FD_FROM_STRAP = 1'b0
) (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic [4:0]            mgmt_addr,
    input  wire logic                  mgmt_wr,
    input  wire logic                  mgmt_rd,
    input  wire logic [15:0]           mgmt_wdata,
    output logic [15:0]                mgmt_rdata,
    output logic                       mgmt_rvalid,
    output logic                       mgmt_rhit,
    input  wire logic                  page_rx_valid,
    input  wire ang_pkg::ang_page_s    page_rx_word,
    input  wire logic                  link_down,
    input  wire logic                  fd_strap,
    output ang_pkg::ang_page_s         rx_page,
    output ang_pkg::ang_test_mode_e    test_mode,
    output logic                       ms_manual_en,
    output logic                       ms_force_master,
    output logic                       ms_force_slave,
    output logic                       adv_multi_port,
    output logic                       adv_full_duplex,
    output logic                       adv_half_duplex,
    output logic                       reflectometry_start
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [15:0]        cfg_r;
    logic [15:0]        cfg_nxt;
    logic [15:0]        cfg_wr_val;
    logic [15:0]        rd_mux;
    logic               hit_pnp;
    logic               hit_cfg;
    logic               wr_pnp;
    logic               wr_cfg;
    logic               strap_meta_r;
    logic               strap_sync_r;
    logic [1:0]         strap_cnt_r;
    logic               strap_load;
    logic               ms_master_nxt;
    logic               ms_slave_nxt;
    logic               refl_nxt;
    logic               ms_master_r;
    logic               ms_slave_r;
    logic               refl_r;
    logic [15:0]        rdata_r;
    logic               rvalid_r;
    logic               rhit_r;
    ang_pkg::ang_page_s page_q;

    // Register select and write strobes
    assign hit_pnp = (mgmt_addr == `ANG_PNP_ADDR);
    assign hit_cfg = (mgmt_addr == `ANG_CFG_ADDR);
    assign wr_pnp  = mgmt_wr && hit_pnp;
    assign wr_cfg  = mgmt_wr && hit_cfg;

    // ****************************************************************
    // Next-page receive register
    // ****************************************************************
    ang_page_capture u_page (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .page_valid (page_rx_valid),
        .page_word  (page_rx_word),
        .wr_en      (wr_pnp),
        .wdata      (mgmt_wdata),
        .page_q     (page_q)
    );

    // ****************************************************************
    // Full duplex strap capture
    // ****************************************************************
    // Strap pin passes two flip-flops before use
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_meta_r <= 1'b0;
            strap_sync_r <= 1'b0;
        end
        else
        begin
            strap_meta_r <= fd_strap;
            strap_sync_r <= strap_meta_r;
        end
    end

    // Counts edges after release until the synchronised strap is valid; both
    // stages sit in reset too, so the pin level only reaches the second stage
    // after the second edge and is taken at the third
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_cnt_r <= `ANG_CNT_ZERO;
        end
        else if (strap_cnt_r != `ANG_CNT_DONE)
        begin
            strap_cnt_r <= strap_cnt_r + `ANG_CNT_ONE;
        end
    end

    // One load cycle, only in the strapped variant
    assign strap_load = FD_FROM_STRAP && (strap_cnt_r == `ANG_STRAP_LOAD);

    // ****************************************************************
    // Gigabit configuration register
    // ****************************************************************
    // Reserved bits 6:0 never take written data
    assign cfg_wr_val = ang_pkg::ang_masked_write(cfg_r, mgmt_wdata, `ANG_CFG_WMASK);

    // Write wins over the strap default; fields take written data directly
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_cfg)
        begin
            cfg_nxt = cfg_wr_val;
        end
        else if (strap_load)
        begin
            cfg_nxt[`ANG_ADV_FD] = strap_sync_r;
        end
    end

    // Forced role follows the next register value so it changes with it
    assign ms_master_nxt = cfg_nxt[`ANG_MS_MANUAL] && cfg_nxt[`ANG_MS_VALUE];
    assign ms_slave_nxt  = cfg_nxt[`ANG_MS_MANUAL] && !cfg_nxt[`ANG_MS_VALUE];

    // Reflectometry start on link drop when enabled
    assign refl_nxt = link_down && cfg_r[`ANG_AUTO_REFL];

    // Configuration and derived control flops
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_r       <= `ANG_CFG_RESET;
            ms_master_r <= 1'b0;
            ms_slave_r  <= 1'b0;
            refl_r      <= 1'b0;
        end
        else
        begin
            cfg_r       <= cfg_nxt;
            ms_master_r <= ms_master_nxt;
            ms_slave_r  <= ms_slave_nxt;
            refl_r      <= refl_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped offsets answer zero with the hit flag low
    assign rd_mux = hit_pnp ? page_q :
                    hit_cfg ? cfg_r :
                    `ANG_RD_NONE;

    // Read data registered one cycle after the request
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_r  <= `ANG_RD_NONE;
            rvalid_r <= 1'b0;
            rhit_r   <= 1'b0;
        end
        else
        begin
            rvalid_r <= mgmt_rd;
            rhit_r   <= mgmt_rd && (hit_pnp || hit_cfg);
            if (mgmt_rd)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign mgmt_rdata          = rdata_r;
    assign mgmt_rvalid         = rvalid_r;
    assign mgmt_rhit           = rhit_r;
    assign rx_page             = page_q;
    assign test_mode           = ang_pkg::ang_test_mode_e'(cfg_r[`ANG_TM_HI:`ANG_TM_LO]);
    assign ms_manual_en        = cfg_r[`ANG_MS_MANUAL];
    assign ms_force_master     = ms_master_r;
    assign ms_force_slave      = ms_slave_r;
    assign adv_multi_port      = cfg_r[`ANG_PORT_TYPE];
    assign adv_full_duplex     = cfg_r[`ANG_ADV_FD];
    assign adv_half_duplex     = cfg_r[`ANG_ADV_HD];
    assign reflectometry_start = refl_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    np_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        mgmt_rd && hit_pnp |=> mgmt_rvalid && mgmt_rhit
                    && mgmt_rdata[15] == $past(page_q.more_pages_flag)
                    && mgmt_rdata == $past(page_q))
        else $error("next-page read data wrong");

    null_page_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) && !$past(page_rx_valid) |->
            page_q == ang_pkg::ang_page_s'(`ANG_PNP_RESET) && page_q.message_page_flag)
        else $error("next-page reset value wrong");

    test_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_cfg |=> test_mode == $past(mgmt_wdata[15:13])
                    ##1 ($past(wr_cfg) || test_mode == $past(test_mode)))
        else $error("test mode not taken from write");

    ms_auto_a: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg_r[`ANG_MS_MANUAL] |-> !ms_force_master && !ms_force_slave)
        else $error("role forced while resolution automatic");

    ms_force_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_cfg && mgmt_wdata[12] |=> ms_force_master == $past(mgmt_wdata[11])
                    && ms_force_slave == !$past(mgmt_wdata[11]))
        else $error("manual role not forced");

    adv_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_cfg |=> {adv_multi_port, adv_full_duplex, adv_half_duplex}
                    == $past(mgmt_wdata[10:8]))
        else $error("advertisement bits not written");

    refl_start_a: assert property (@(posedge clock) disable iff (sys_rst)
        link_down |=> reflectometry_start == $past(cfg_r[`ANG_AUTO_REFL]))
        else $error("reflectometry start wrong after link drop");

    refl_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        !link_down |=> !reflectometry_start)
        else $error("reflectometry started without link drop");

    rsvd_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        mgmt_rd && hit_cfg |=> mgmt_rvalid && mgmt_rdata[6:0] == `ANG_RSVD_ZERO)
        else $error("reserved config bits read nonzero");

    // ****************************************************************
    // Checks on reset values, strap load, held contents, read data and forced role
    // ****************************************************************
    cfg_reset_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> test_mode == ang_pkg::ANG_TM_NORMAL && !ms_manual_en
                    && !adv_multi_port && adv_half_duplex && !reflectometry_start)
        else $error("configuration reset value wrong");

    fd_reset_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> adv_full_duplex)
        else $error("full duplex advertisement reset value wrong");

    strap_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        strap_load && !wr_cfg |=> adv_full_duplex == $past(strap_sync_r))
        else $error("strapped full duplex not loaded");

    cfg_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !wr_cfg && !strap_load |=> cfg_r == $past(cfg_r))
        else $error("configuration changed without a write");

    cfg_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        mgmt_rd && hit_cfg |=> mgmt_rhit && mgmt_rdata == $past(cfg_r))
        else $error("configuration read data wrong");

    ms_role_a: assert property (@(posedge clock) disable iff (sys_rst)
        ms_manual_en |-> ms_force_master == cfg_r[`ANG_MS_VALUE]
                    && ms_force_slave == !cfg_r[`ANG_MS_VALUE])
        else $error("forced role disagrees with configuration value");

    ms_excl_a: assert property (@(posedge clock) disable iff (sys_rst)
        !(ms_force_master && ms_force_slave))
        else $error("master and slave forced together");

    page_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !page_rx_valid && !wr_pnp |=> rx_page == $past(rx_page))
        else $error("receive register changed with no page or write");

endmodule
